// ### design/pah_adapter.sv
// processor-side interface of a two-section peripheral adapter
// assumes enable and all bus inputs synchronous to sys_clk
`timescale 1ns/1ns
`include "pah_params.svh"
module pah_adapter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic master_clear_n,
  // processor bus
  input wire logic enable,
  input wire logic rd_wr,
  input wire logic sel_hi_a,
  input wire logic sel_hi_b,
  input wire logic sel_lo_n,
  input wire logic reg_pick_0,
  input wire logic reg_pick_1,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // interrupt requests, open drain
  output logic int_req_a_n,
  output logic int_req_a_oe,
  output logic int_req_b_n,
  output logic int_req_b_oe,
  // peripheral lines
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  input wire logic ctl_in_a,
  input wire logic ctl_in_b,
  input wire logic ctl_io_a_in,
  output logic ctl_io_a_out,
  output logic ctl_io_a_oe,
  input wire logic ctl_io_b_in,
  output logic ctl_io_b_out,
  output logic ctl_io_b_oe
);
  logic e_q;
  logic [7:0] rdata_q;
  logic clr;
  logic selected;
  logic e_fall;
  logic e_rise;
  logic acc;
  logic [1:0] pick;
  logic [1:0] wr_ctl;
  logic [1:0] wr_ddr;
  logic [1:0] wr_out;
  logic [1:0] rd_data;
  logic [1:0] irq_oe;
  logic [1:0] c2_out;
  logic [1:0] c2_oe;
  logic [1:0] c2_in;
  logic [1:0] c1_in;
  logic [1:0] flags [2];
  pah_pkg::pah_sect_s regs [2];
  logic [7:0] rd_mux;

  // true when section s currently exposes its data, not its direction
  function automatic logic data_pick(input logic [5:0] ctl);
    data_pick = ctl[`PAH_CR_ACCESS];
  endfunction

  assign clr = rst | ~master_clear_n;
  assign selected = sel_hi_a & sel_hi_b & ~sel_lo_n;
  // bus acts on the falling edge of enable, sampled at the clock
  assign e_fall = e_q & ~enable;
  assign e_rise = ~e_q & enable;
  assign acc = e_fall & selected;
  assign pick = {reg_pick_1, reg_pick_0};

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sect
      logic is_data;
      logic is_ctl;
      assign is_data = pick == (s ? `PAH_SEL_DATA_B : `PAH_SEL_DATA_A);
      assign is_ctl = pick == (s ? `PAH_SEL_CTL_B : `PAH_SEL_CTL_A);
      assign wr_ctl[s] = acc & ~rd_wr & is_ctl;
      assign wr_ddr[s] = acc & ~rd_wr & is_data & ~data_pick(regs[s].ctl);
      assign wr_out[s] = acc & ~rd_wr & is_data & data_pick(regs[s].ctl);
      assign rd_data[s] = acc & rd_wr & is_data &
                          data_pick(regs[s].ctl);
      pah_section u_sect (
        .sys_clk(sys_clk),
        .rst(clr),
        .wr_ctl(wr_ctl[s]),
        .wr_ddr(wr_ddr[s]),
        .wr_out(wr_out[s]),
        .rd_data(rd_data[s]),
        .desel_e(e_fall & ~selected),
        .e_high(enable),
        .is_b(s == 1),
        .wdata(data_in),
        .ctl_in(c1_in[s]),
        .ctl_io_in(c2_in[s]),
        .ctl_io_out(c2_out[s]),
        .ctl_io_oe(c2_oe[s]),
        .regs(regs[s]),
        .flags(flags[s]),
        .irq_n_oe(irq_oe[s])
      );
    end
  endgenerate

  assign c1_in = {ctl_in_b, ctl_in_a};
  assign c2_in = {ctl_io_b_in, ctl_io_a_in};

  // port word: inputs from pins, outputs from output register,
  // or the direction register while the access bit is clear
  function automatic logic [7:0] port_word(
      input pah_pkg::pah_sect_s r,
      input logic [7:0] pins);
    if (data_pick(r.ctl)) begin
      port_word = (pins & ~r.ddr) | (r.outr & r.ddr);
    end else begin
      port_word = r.ddr;
    end
  endfunction

  // read decode: flags sit above the six writable control bits
  function automatic logic [7:0] read_word(
      input logic [1:0] p,
      input pah_pkg::pah_sect_s ra,
      input pah_pkg::pah_sect_s rb,
      input logic [1:0] fa,
      input logic [1:0] fb,
      input logic [7:0] pin_a,
      input logic [7:0] pin_b);
    logic [7:0] w;
    w = `PAH_REG_RESET;
    if (p == `PAH_SEL_CTL_A) begin
      w = {fa[0], fa[1], ra.ctl};
    end else if (p == `PAH_SEL_CTL_B) begin
      w = {fb[0], fb[1], rb.ctl};
    end else if (p == `PAH_SEL_DATA_A) begin
      w = port_word(ra, pin_a);
    end else begin
      w = port_word(rb, pin_b);
    end
    read_word = w;
  endfunction

  assign rd_mux = read_word(pick, regs[0], regs[1], flags[0], flags[1],
                            port_a_in, port_b_in);

  // bus driven only during enable high of a selected read
  assign data_oe = enable & selected & rd_wr;
  assign data_out = rdata_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      e_q <= 1'b0;
      rdata_q <= `PAH_REG_RESET;
    end else begin
      e_q <= enable;
      // latched on the clock where the enable rise is seen, so data is steady from then until the next rise
      if (e_rise) rdata_q <= rd_mux;
    end
  end

  assign int_req_a_n = 1'b0;
  assign int_req_b_n = 1'b0;
  assign int_req_a_oe = irq_oe[0];
  assign int_req_b_oe = irq_oe[1];
  assign port_a_out = regs[0].outr;
  assign port_a_oe = regs[0].ddr;
  assign port_b_out = regs[1].outr;
  assign port_b_oe = regs[1].ddr;
  assign ctl_io_a_out = c2_out[0];
  assign ctl_io_a_oe = c2_oe[0];
  assign ctl_io_b_out = c2_out[1];
  assign ctl_io_b_oe = c2_oe[1];
endmodule

// ### design/pah_params.svh
// constants for the peripheral adapter host interface
// assumes inclusion by bare name from design files
`ifndef PAH_PARAMS_SVH
`define PAH_PARAMS_SVH
`define PAH_SEL_DATA_A 2'h0
`define PAH_SEL_CTL_A 2'h1
`define PAH_SEL_DATA_B 2'h2
`define PAH_SEL_CTL_B 2'h3
`define PAH_CR_GATE 0
`define PAH_CR_EDGE 1
`define PAH_CR_ACCESS 2
`define PAH_CR_C2_B3 3
`define PAH_CR_C2_B4 4
`define PAH_CR_C2_MODE 5
`define PAH_CR_FLAG2 6
`define PAH_CR_FLAG1 7
`define PAH_CR_RESET 6'h00
`define PAH_REG_RESET 8'h00
`endif

// ### design/pah_pkg.sv
// types for the peripheral adapter host interface
// assumes pah_params.svh constants alongside
package pah_pkg;
  typedef struct packed {
    logic [5:0] ctl;
    logic [7:0] ddr;
    logic [7:0] outr;
  } pah_sect_s;
  typedef enum logic [1:0] {
    PAH_IDLE,
    PAH_HIGH
  } pah_phase_e;
endpackage

// ### design/pah_section.sv
// one port section: control, direction, output regs, flags, c2 output
// assumes strobes are single-cycle and derived from enable falling edge
`timescale 1ns/1ns
`include "pah_params.svh"
module pah_section (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // strobes from bus logic
  input wire logic wr_ctl,
  input wire logic wr_ddr,
  input wire logic wr_out,
  input wire logic rd_data,
  input wire logic desel_e,
  input wire logic e_high,
  input wire logic is_b,
  input wire logic [7:0] wdata,
  // peripheral control lines
  input wire logic ctl_in,
  input wire logic ctl_io_in,
  output logic ctl_io_out,
  output logic ctl_io_oe,
  // state
  output pah_pkg::pah_sect_s regs,
  output logic [1:0] flags,
  output logic irq_n_oe
);
  logic [5:0] ctl_q;
  logic [7:0] ddr_q;
  logic [7:0] out_q;
  logic [1:0] flag_q;
  logic [1:0] allow_q;
  logic [1:0] armed_q;
  logic [1:0] prev_q;
  logic c2_q;
  logic [1:0] line;
  logic [1:0] pol;
  logic [1:0] act_edge;
  logic [1:0] en;
  logic c2_out_mode;
  logic c2_trig;

  assign line = {ctl_io_in, ctl_in};
  assign pol = {ctl_q[`PAH_CR_C2_B4], ctl_q[`PAH_CR_EDGE]};
  assign c2_out_mode = ctl_q[`PAH_CR_C2_MODE];
  // active edge: level now at active polarity, was at inactive
  // both lines may be active at once, so each bit is judged alone
  assign act_edge = (line ~^ pol) & (prev_q ^ pol);
  assign en = {ctl_q[`PAH_CR_C2_B3], ctl_q[`PAH_CR_GATE]};
  assign irq_n_oe = |(flag_q & en & {~c2_out_mode, 1'b1});
  assign flags = flag_q;
  assign regs = '{ctl: ctl_q, ddr: ddr_q, outr: out_q};
  assign c2_trig = is_b ? wr_out : rd_data;
  assign ctl_io_out = c2_q;
  assign ctl_io_oe = c2_out_mode;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_q <= `PAH_CR_RESET;
      ddr_q <= `PAH_REG_RESET;
      out_q <= `PAH_REG_RESET;
      flag_q <= 2'h0;
      allow_q <= 2'h0;
      armed_q <= 2'h0;
      prev_q <= 2'h3;
      c2_q <= 1'b0;
    end else begin
      prev_q <= line;
      if (wr_ctl) ctl_q <= wdata[5:0];
      if (wr_ddr) ddr_q <= wdata;
      if (wr_out) out_q <= wdata;
      // armed by an enable high phase seen at the inactive level
      armed_q <= (armed_q & ~act_edge) | ({2{e_high}} & (line ^ pol));
      if (desel_e) allow_q <= 2'h3;
      else if (rd_data) allow_q <= 2'h0;
      // set beats clear: edge in the clearing cycle still lands
      flag_q <= ((rd_data ? 2'h0 : flag_q) |
                 (act_edge & armed_q & allow_q &
                  {~c2_out_mode, 1'b1})) & 2'h3;
      // c2 output: b4=1 manual level b3, else handshake/pulse
      if (!c2_out_mode) c2_q <= 1'b1;
      else if (ctl_q[`PAH_CR_C2_B4]) c2_q <= ctl_q[`PAH_CR_C2_B3];
      else if (c2_trig) c2_q <= 1'b0;
      else if (ctl_q[`PAH_CR_C2_B3] && desel_e) c2_q <= 1'b1;
      else if (!ctl_q[`PAH_CR_C2_B3] && act_edge[0]) c2_q <= 1'b1;
    end
  end
endmodule

// ### test/pah_adapter_asserts.sv
// port checks for the adapter's processor side
// assumes one clock; bound into pah_adapter below
`timescale 1ns/1ns
module pah_chk (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic master_clear_n,
  // processor bus
  input wire logic enable,
  input wire logic rd_wr,
  input wire logic sel_hi_a,
  input wire logic sel_hi_b,
  input wire logic sel_lo_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  // requests and ports
  input wire logic int_req_a_n,
  input wire logic int_req_b_n,
  input wire logic int_req_a_oe,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic en_q;
  logic wgo_q;
  wire sel = sel_hi_a && sel_hi_b && !sel_lo_n;
  // a write may land one edge after the enable fall is seen
  wire wgo = en_q && !enable && sel && !rd_wr;
  always_ff @(posedge sys_clk) begin
    en_q <= enable;
    wgo_q <= wgo;
  end
  drive_match_a: assert property (data_oe == (enable && sel && rd_wr))
    else $error("bus drive wrong");
  bus_idle_a: assert property (!enable |-> !data_oe)
    else $error("bus drive idle");
  select_gate_a: assert property (data_oe |-> sel)
    else $error("drive deselected");
  req_a_low_a: assert property (int_req_a_n == 1'b0)
    else $error("request a level");
  req_b_low_a: assert property (int_req_b_n == 1'b0)
    else $error("request b level");
  clear_all_a: assert property (!master_clear_n |=> !int_req_a_oe
    && port_a_oe == 8'h00 && port_a_out == 8'h00 && port_b_oe == 8'h00)
    else $error("clear missed");
  write_only_a: assert property (!wgo && !wgo_q && master_clear_n
    |=> $stable({port_a_out, port_a_oe, port_b_oe}))
    else $error("register moved");
  read_hold_a: assert property (!$rose(enable) |=> $stable(data_out))
    else $error("read data moved");
  cover property (wgo);
  cover property (data_oe);
  cover property ($rose(int_req_a_oe));
endmodule

bind pah_adapter pah_chk u_chk (.sys_clk, .rst, .master_clear_n, .enable,
  .rd_wr, .sel_hi_a, .sel_hi_b, .sel_lo_n, .data_out, .data_oe,
  .int_req_a_n, .int_req_b_n, .int_req_a_oe, .port_a_out, .port_a_oe,
  .port_b_oe);

// ### test/pah_cpu.sv
// processor bus model: free-running enable, one access per call
// assumes sys_clk runs; enable is two clocks high, two low
`timescale 1ns/1ns
module pah_cpu (
  // clock
  input wire logic sys_clk,
  // bus towards the adapter
  output logic enable = 1'b0,
  output logic rd_wr = 1'b1,
  output logic sel_hi_a = 1'b0,
  output logic sel_hi_b = 1'b0,
  output logic sel_lo_n = 1'b1,
  output logic reg_pick_0 = 1'b0,
  output logic reg_pick_1 = 1'b0,
  output logic [7:0] data_in = 8'h00,
  input wire logic [7:0] data_out
);
  logic [1:0] ph_q = 2'h0;
  // never stopped: the flag logic is conditioned by it
  always @(posedge sys_clk) begin
    ph_q <= ph_q + 2'h1;
    enable <= ph_q[1];
  end
  task automatic access(input logic [2:0] s, input logic rw,
      input logic [1:0] p, input logic [7:0] w, output logic [7:0] r);
    @(negedge enable);
    @(posedge sys_clk);
    {sel_hi_a, sel_hi_b, sel_lo_n} <= s;
    {reg_pick_1, reg_pick_0} <= p;
    rd_wr <= rw;
    data_in <= w;
    @(negedge enable);
    @(posedge sys_clk);
    r = data_out;
    // no valid address between cycles, so nothing is selected
    {sel_hi_a, sel_hi_b, sel_lo_n} <= 3'b001;
    rd_wr <= 1'b1;
    data_in <= ~w;
  endtask
endmodule

// ### test/tb_peripheral_adapter_host_interface.sv
// self-checking bench for the adapter host interface
// assumes pah_cpu drives the bus and pah_chk is bound in
`timescale 1ns/1ns
module tb_peripheral_adapter_host_interface;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic master_clear_n = 1'b1;
  logic enable, rd_wr, sel_hi_a, sel_hi_b, sel_lo_n, reg_pick_0, reg_pick_1;
  logic [7:0] data_in, data_out, port_a_out, port_a_oe, port_b_out, port_b_oe;
  logic int_req_a_oe, int_req_b_oe;
  logic [1:0] cio_oe, cio_out;
  logic [1:0] cin = 2'b01;
  logic [7:0] pr [2] = '{8'h00, 8'h00};
  logic [7:0] m_ctl [2] = '{8'h00, 8'h00};
  logic [7:0] m_ddr [2] = '{8'h00, 8'h00};
  logic [7:0] m_out [2] = '{8'h00, 8'h00};
  logic m_flg [2] = '{1'b0, 1'b0};
  int seed = 32'h009c8468;
  int checks = 0;
  int n_fail = 0;
  always #10 sys_clk = ~sys_clk;
  pah_cpu cpu (.sys_clk, .enable, .rd_wr, .sel_hi_a, .sel_hi_b, .sel_lo_n,
    .reg_pick_0, .reg_pick_1, .data_in, .data_out);
  // pins read back what the port drives, elsewhere a random level
  pah_adapter DUT (.sys_clk, .rst, .master_clear_n, .enable, .rd_wr,
    .sel_hi_a, .sel_hi_b, .sel_lo_n, .reg_pick_0, .reg_pick_1, .data_in,
    .data_out, .data_oe(), .int_req_a_n(), .int_req_a_oe, .int_req_b_n(),
    .int_req_b_oe, .port_a_out, .port_a_oe, .port_b_out, .port_b_oe,
    .port_a_in((port_a_out & port_a_oe) | (pr[0] & ~port_a_oe)),
    .port_b_in((port_b_out & port_b_oe) | (pr[1] & ~port_b_oe)),
    .ctl_in_a(cin[0]), .ctl_in_b(cin[1]), .ctl_io_a_in(1'b1),
    .ctl_io_b_in(1'b1), .ctl_io_a_out(cio_out[0]),
    .ctl_io_a_oe(cio_oe[0]), .ctl_io_b_out(cio_out[1]),
    .ctl_io_b_oe(cio_oe[1]));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] w);
    logic [7:0] r;
    cpu.access(3'b110, 1'b0, p, w, r);
    if (p[0]) m_ctl[p[1]] = w;
    else if (m_ctl[p[1]][2]) m_out[p[1]] = w;
    else m_ddr[p[1]] = w;
  endtask
  task automatic rd(input logic [1:0] p);
    logic [7:0] r, e;
    int i;
    i = p[1];
    cpu.access(3'b110, 1'b1, p, 8'h00, r);
    if (p[0]) e = {m_flg[i], 1'b0, m_ctl[i][5:0]};
    else if (m_ctl[i][2]) e = (m_out[i] & m_ddr[i]) | (pr[i] & ~m_ddr[i]);
    else e = m_ddr[i];
    if (!p[0] && m_ctl[i][2]) m_flg[i] = 1'b0;
    cmp("read", e, r);
  endtask
  task automatic ports;
    repeat (2) @(posedge sys_clk);
    cmp("dir a", m_ddr[0], port_a_oe);
    cmp("out a", m_out[0], port_a_out);
    cmp("dir b", m_ddr[1], port_b_oe);
    cmp("out b", m_out[1], port_b_out);
    cmp("c2 dir", {6'h00, m_ctl[1][5], m_ctl[0][5]}, {6'h00, cio_oe});
    cmp("c2 out", 8'h03, {6'h00, cio_out});
  endtask
  task automatic irq(input logic s, input logic g);
    wr({s, 1'b1}, {6'h01, s, g});
    cin[s] <= ~s;
    repeat (8) @(posedge sys_clk);
    rd({s, 1'b0});
    repeat (8) @(posedge sys_clk);
    cin[s] <= s;
    m_flg[s] = 1'b1;
    repeat (8) @(posedge sys_clk);
    cmp("irq", {7'h00, g}, {7'h00, s ? int_req_b_oe : int_req_a_oe});
    rd({s, 1'b1});
    rd({s, 1'b0});
    repeat (3) @(posedge sys_clk);
    cmp("irq", 8'h00, {7'h00, s ? int_req_b_oe : int_req_a_oe});
  endtask
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    logic [7:0] r;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    pr[0] <= 8'($random(seed));
    pr[1] <= 8'($random(seed));
    ports;
    for (int s = 0; s < 2; s++) begin
      wr({s[0], 1'b1}, 8'h00);
      wr({s[0], 1'b0}, 8'($random(seed)));
      rd({s[0], 1'b0});
      wr({s[0], 1'b1}, 8'hc4);
      wr({s[0], 1'b0}, 8'($random(seed)));
      rd({s[0], 1'b0});
      rd({s[0], 1'b1});
    end
    for (int k = 0; k < 3; k++) begin
      cpu.access(3'b110 ^ (3'b001 << k), 1'b0, 2'h0, 8'h5a, r);
      ports;
    end
    for (int c = 0; c < 4; c++) irq(c[0], c[1]);
    master_clear_n <= 1'b0;
    @(posedge sys_clk);
    master_clear_n <= 1'b1;
    m_ctl = '{8'h00, 8'h00};
    m_ddr = '{8'h00, 8'h00};
    m_out = '{8'h00, 8'h00};
    ports;
    rd(2'h1);
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    finish_test;
  end
endmodule
